// >>> hdl/tasm_pkg.sv
package tasm_pkg;
  // ---------------------------------------------
  // Register indexes (command bytes)
  // ---------------------------------------------
  localparam logic [7:0] REG_REMOTE1 = 8'h01;
  localparam logic [7:0] REG_CONFIG1 = 8'h41;
  localparam logic [7:0] REG_ALERT_MASK = 8'h42;
  localparam logic [7:0] REG_OVERTEMP_MASK_CONFIG = 8'h43;
  localparam logic [7:0] REG_ALERT_STATUS = 8'h44;
  localparam logic [7:0] REG_OT_STATUS = 8'h45;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h46;
  localparam logic [7:0] REG_LOCAL_ALERT_LIM = 8'h17;
  localparam logic [7:0] REG_REMOTE_ALERT_LIM = 8'h11;
  localparam logic [7:0] REG_REMOTE_OT_LIM = 8'h21;
  localparam logic [7:0] REG_MFR_ID = 8'h0A;
  // ---------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LOCAL_ALERT_LIM = 8'h5A;
  localparam logic [55:0] RST_ALERT_LIM = 56'h5A_64_64_64_64_7F_6E;
  localparam logic [47:0] RST_OT_LIM = 48'h5A_5A_7F_00_00_6E;
  localparam logic [5:0] OT_CHAN_MASK = 6'h39;
  localparam logic [7:0] OT_CFG_WMASK = 8'h39;
  localparam logic [7:0] ALERT_MASK_WMASK = 8'h7F;
  localparam logic [7:0] CFG1_WMASK = 8'hF8;
  localparam int CFG1_RCANCEL_BIT = 3;
  localparam logic [7:0] OT_HYST = 8'h04;
  localparam logic [7:0] MFR_ID_VALUE = 8'h11; // Arbitrary value
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int RCANCEL_EXTRA_MS = 125;
  localparam int RCANCEL_EXTRA_CYC = RCANCEL_EXTRA_MS * (CLK_HZ / 1000);
  localparam int SLOT_CYC = 16;
  localparam int NCH = 7;
endpackage : tasm_pkg

// >>> hdl/tasm_chan.sv
`timescale 1ns/1ps
module tasm_chan (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Result strobe, temperature, limits and enable
  input wire logic result_valid,
  input wire logic [7:0] temp,
  input wire logic [7:0] alert_limit,
  input wire logic [7:0] ot_limit,
  input wire logic ot_en,
  // Flags
  output logic alert_hit,
  output logic ot_active_r
);
  logic ot_nxt;
  wire above_alert = temp > alert_limit;
  wire above_ot = temp > ot_limit;
  wire below_hyst = {1'b0, temp} < ({1'b0, ot_limit} - {1'b0, tasm_pkg::OT_HYST});
  assign alert_hit = result_valid && above_alert;
  // Condition latches until temperature drops under limit minus hysteresis
  assign ot_nxt = !ot_en ? 1'b0 : (result_valid && above_ot) ? 1'b1 : (result_valid && below_hyst) ? 1'b0 : ot_active_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ot_active_r <= 1'b0;
    end else begin
      ot_active_r <= ot_nxt;
    end
  end
endmodule : tasm_chan

// >>> hdl/tasm_top.sv
`timescale 1ns/1ps
module tasm_top #(
  parameter int RCANCEL_CYC = tasm_pkg::RCANCEL_EXTRA_CYC,
  parameter int SLOT_CYC = tasm_pkg::SLOT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // Measurement front end
  input wire logic [55:0] temp_in,
  input wire logic [5:0] diode_open,
  input wire logic [5:0] anode_at_supply,
  output logic [2:0] meas_chan_r,
  output logic rcancel_active_r,
  // Alarm outputs
  output logic alert_output_r,
  output logic overtemp_output_r
);
  localparam int NCH = tasm_pkg::NCH;
  initial begin
    if (RCANCEL_CYC < 1 || SLOT_CYC < 2) begin
      $error("tasm_top: slot counts too small");
    end
  end
  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [7:0] cfg1_r, alert_mask_r, ot_mask_r, alert_stat_r, ot_stat_r, fault_stat_r;
  logic [55:0] alert_lim_r;
  logic [47:0] ot_lim_r;
  logic [2:0] chan_r, chan_nxt;
  logic [31:0] slot_cnt_r;
  logic [6:0] valid_vec;
  logic [6:0] alert_hit;
  logic [5:0] ot_act;
  // Marks the cycle after a remote conversion, when its latched condition is fresh
  logic [5:0] ot_done_r;
  wire wr_cfg1 = reg_wr && reg_addr == tasm_pkg::REG_CONFIG1;
  wire wr_amask = reg_wr && reg_addr == tasm_pkg::REG_ALERT_MASK;
  wire wr_otmask = reg_wr && reg_addr == tasm_pkg::REG_OVERTEMP_MASK_CONFIG;
  wire rd_astat = reg_rd && reg_addr == tasm_pkg::REG_ALERT_STATUS;
  wire rd_otstat = reg_rd && reg_addr == tasm_pkg::REG_OT_STATUS;
  wire [7:0] lim_idx = reg_addr - tasm_pkg::REG_REMOTE_ALERT_LIM;
  wire [7:0] otl_idx = reg_addr - tasm_pkg::REG_REMOTE_OT_LIM;
  wire wr_alim = reg_wr && (lim_idx < 8'h07);
  wire wr_otlim = reg_wr && (otl_idx < 8'h06) && tasm_pkg::OT_CHAN_MASK[otl_idx[2:0]];
  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  wire [5:0] fault_now = diode_open | anode_at_supply;
  wire rcancel_on = cfg1_r[tasm_pkg::CFG1_RCANCEL_BIT];
  // Only channel 1 (slot 0) gets the cancellation time
  wire [31:0] slot_len = (chan_r == 3'h0 && rcancel_on) ? SLOT_CYC + RCANCEL_CYC : SLOT_CYC;
  wire slot_end = slot_cnt_r >= slot_len - 1;
  // Next non-faulted channel; local (6) is never skipped
  always_comb begin
    chan_nxt = 3'h6;
    for (int k = 6; k >= 1; k--) begin
      int c;
      c = chan_r + k;
      if (c >= NCH) c = c - NCH;
      if (c == 6 || !fault_now[c]) chan_nxt = 3'(c);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_r <= 3'h6;
      slot_cnt_r <= 32'h0;
    end else if (slot_end) begin
      chan_r <= chan_nxt;
      slot_cnt_r <= 32'h0;
    end else begin
      slot_cnt_r <= slot_cnt_r + 32'h1;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign valid_vec[g] = slot_end && chan_r == 3'(g);
      if (g < 6) begin : g_rem
        tasm_chan u_ch (
          .ref_clk(ref_clk),
          .reset(reset),
          .result_valid(valid_vec[g]),
          .temp(temp_in[8*g +: 8]),
          .alert_limit(alert_lim_r[8*g +: 8]),
          .ot_limit(ot_lim_r[8*g +: 8]),
          .ot_en(tasm_pkg::OT_CHAN_MASK[g]),
          .alert_hit(alert_hit[g]),
          .ot_active_r(ot_act[g])
        );
      end else begin : g_loc
        assign alert_hit[g] = valid_vec[g] && temp_in[8*g +: 8] > alert_lim_r[8*g +: 8];
      end
    end
  endgenerate
  // ---------------------------------------------
  // Status and config registers
  // ---------------------------------------------
  // Only the channel that just converted may set its bit, so a read stays clear until then
  wire [7:0] ot_set = {2'b00, ot_act & ot_done_r} & {2'b00, tasm_pkg::OT_CHAN_MASK};
  // Set wins over read-clear
  wire [7:0] astat_nxt = ((rd_astat ? 8'h00 : alert_stat_r) | {1'b0, alert_hit}) & 8'h7F;
  wire [7:0] otstat_nxt = (rd_otstat ? 8'h00 : ot_stat_r) | ot_set;
  wire [6:0] amask7 = alert_mask_r[6:0];
  wire [5:0] otmask6 = ot_mask_r[5:0];
  wire alert_any = |(astat_nxt[6:0] & ~amask7);
  // Output follows condition, not status bits, so a read cannot release it
  wire ot_any = |(ot_act & tasm_pkg::OT_CHAN_MASK & ~otmask6);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg1_r <= tasm_pkg::RST_ZERO;
      alert_mask_r <= tasm_pkg::RST_ZERO;
      ot_mask_r <= tasm_pkg::RST_ZERO;
      alert_stat_r <= tasm_pkg::RST_ZERO;
      ot_stat_r <= tasm_pkg::RST_ZERO;
      fault_stat_r <= tasm_pkg::RST_ZERO;
      alert_lim_r <= tasm_pkg::RST_ALERT_LIM;
      ot_lim_r <= tasm_pkg::RST_OT_LIM;
      alert_output_r <= 1'b0;
      overtemp_output_r <= 1'b0;
      meas_chan_r <= 3'h6;
      rcancel_active_r <= 1'b0;
      ot_done_r <= 6'h00;
    end else begin
      ot_done_r <= valid_vec[5:0];
      if (wr_cfg1) cfg1_r <= reg_wdata & tasm_pkg::CFG1_WMASK;
      if (wr_amask) alert_mask_r <= reg_wdata & tasm_pkg::ALERT_MASK_WMASK;
      if (wr_otmask) ot_mask_r <= reg_wdata & tasm_pkg::OT_CFG_WMASK;
      if (wr_alim) alert_lim_r[8*lim_idx[2:0] +: 8] <= reg_wdata;
      if (wr_otlim) ot_lim_r[8*otl_idx[2:0] +: 8] <= reg_wdata;
      alert_stat_r <= astat_nxt;
      ot_stat_r <= otstat_nxt;
      fault_stat_r <= {1'b0, fault_now, 1'b0};
      alert_output_r <= alert_any;
      overtemp_output_r <= ot_any;
      meas_chan_r <= slot_end ? chan_nxt : chan_r;
      rcancel_active_r <= rcancel_on && (slot_end ? chan_nxt == 3'h0 : chan_r == 3'h0);
    end
  end
  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  wire [7:0] rd_mux =
    (reg_addr == tasm_pkg::REG_CONFIG1) ? cfg1_r :
    (reg_addr == tasm_pkg::REG_ALERT_MASK) ? alert_mask_r :
    (reg_addr == tasm_pkg::REG_OVERTEMP_MASK_CONFIG) ? ot_mask_r :
    (reg_addr == tasm_pkg::REG_ALERT_STATUS) ? alert_stat_r :
    (reg_addr == tasm_pkg::REG_OT_STATUS) ? ot_stat_r :
    (reg_addr == tasm_pkg::REG_FAULT_STATUS) ? fault_stat_r :
    (reg_addr == tasm_pkg::REG_MFR_ID) ? tasm_pkg::MFR_ID_VALUE :
    (lim_idx < 8'h07) ? alert_lim_r[8*lim_idx[2:0] +: 8] :
    (otl_idx < 8'h06) ? ot_lim_r[8*otl_idx[2:0] +: 8] : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (reset) reg_rdata_r <= 8'h00;
    else if (reg_rd) reg_rdata_r <= rd_mux;
  end
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  ot_mask_reset_a: assert property (@(posedge ref_clk) $fell(reset) |-> ot_mask_r == 8'h00)
    else $error("ot mask not zero after reset");
  ot_mask_resv_a: assert property (@(posedge ref_clk) disable iff (reset) (ot_mask_r & 8'hC6) == 8'h00)
    else $error("ot mask reserved bit set");
  astat_msb_a: assert property (@(posedge ref_clk) disable iff (reset) !alert_stat_r[7])
    else $error("alert status msb set");
  remote_alert_a: assert property (@(posedge ref_clk) disable iff (reset) alert_hit[0] |=> alert_stat_r[0])
    else $error("remote alert bit not set");
  local_alert_a: assert property (@(posedge ref_clk) disable iff (reset) alert_hit[6] |=> alert_stat_r[6])
    else $error("local alert bit not set");
  rcancel_slot_a: assert property (@(posedge ref_clk) disable iff (reset)
    (slot_cnt_r == 32'h0 && chan_r == 3'h0 && rcancel_on) |-> slot_len == 32'(SLOT_CYC + RCANCEL_CYC))
    else $error("cancel slot length wrong");
  fault_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
    (slot_end && chan_nxt != 3'h6) |-> !fault_now[chan_nxt])
    else $error("faulted channel measured");
  fault_bits_a: assert property (@(posedge ref_clk) disable iff (reset) ##1 fault_stat_r == {1'b0, $past(fault_now), 1'b0})
    else $error("fault status mismatch");
  alert_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
    (astat_nxt[6:0] & alert_mask_r[6:0]) == astat_nxt[6:0] |=> !alert_output_r)
    else $error("masked alert asserted");
  ot_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_otstat && ot_any ##1 ot_any |=> overtemp_output_r)
    else $error("ot output released by read");
  ot_out_a: assert property (@(posedge ref_clk) disable iff (reset) ##1 overtemp_output_r == $past(ot_any))
    else $error("ot output mismatch");
  c_alert_c: cover property (@(posedge ref_clk) alert_output_r);
  c_ot_c: cover property (@(posedge ref_clk) overtemp_output_r);
  c_skip_c: cover property (@(posedge ref_clk) slot_end && fault_now != 6'h00);
  c_rcancel_c: cover property (@(posedge ref_clk) rcancel_active_r);
endmodule : tasm_top

// >>> test/tasm_host.sv
`timescale 1ns/1ps
module tasm_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Data scrambled once the strobe drops, so no stale byte looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata_r;
  endtask : rd
  // Unused channels masked at the start of the fault test
  task automatic mask_unused(input logic [6:0] u);
    wr(tasm_pkg::REG_ALERT_MASK, {1'b0, u});
    wr(tasm_pkg::REG_OVERTEMP_MASK_CONFIG, {2'b00, u[5:0]} & tasm_pkg::OT_CFG_WMASK);
  endtask : mask_unused
endmodule : tasm_host

// >>> test/tasm_top_tb.sv
`timescale 1ns/1ps
module tasm_top_tb;
  localparam int RC = 20;
  localparam int SL = 16;
  localparam int SEQ = 2 * (7 * SL + RC) + 8;
  logic ref_clk, reset, reg_wr, reg_rd, rc_seen, rcancel_active_r, alert_output_r, overtemp_output_r;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d;
  logic [55:0] temp_in;
  logic [5:0] diode_open, anode_at_supply;
  logic [2:0] meas_chan_r;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  tasm_top #(.RCANCEL_CYC(RC), .SLOT_CYC(SL)) u_tasm_top (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .temp_in(temp_in),
    .diode_open(diode_open), .anode_at_supply(anode_at_supply), .meas_chan_r(meas_chan_r),
    .rcancel_active_r(rcancel_active_r), .alert_output_r(alert_output_r), .overtemp_output_r(overtemp_output_r));
  tasm_host u_tasm_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (rcancel_active_r === 1'b1) rc_seen = 1'b1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic drive(input logic [55:0] t, input logic [5:0] op, input logic [5:0] vs);
    step(1);
    temp_in = t;
    diode_open = op;
    anode_at_supply = vs;
  endtask : drive
  // Returns just after the given channel's slot has begun
  task automatic wait_chan(input logic [2:0] c);
    for (int i = 0; i < 500 && meas_chan_r === c; i++) step(1);
    for (int i = 0; i < 500 && meas_chan_r !== c; i++) step(1);
  endtask : wait_chan
  // Length of the next full channel 1 slot
  task automatic slot_len(output int k);
    k = 0;
    for (int i = 0; i < 500 && meas_chan_r === 3'h0; i++) step(1);
    for (int i = 0; i < 500 && meas_chan_r !== 3'h0; i++) step(1);
    while (meas_chan_r === 3'h0 && k < 500) begin
      step(1);
      k++;
    end
  endtask : slot_len
  task automatic t_reset();
    u_tasm_host.rd(8'h43, d);
    chk("ot mask", 8'h00, d);
    u_tasm_host.rd(8'h44, d);
    chk("alert status", 8'h00, d);
    u_tasm_host.wr(8'h43, 8'hFF);
    u_tasm_host.rd(8'h43, d);
    chk("ot mask wr", 8'h39, d);
    u_tasm_host.wr(8'h43, 8'h00);
  endtask : t_reset
  task automatic t_alert();
    drive(56'h60_00_00_00_70_00_00, 6'h00, 6'h00);
    step(SEQ);
    chk("alert out", 8'h01, {7'h00, alert_output_r});
    u_tasm_host.wr(8'h42, 8'h44);
    step(SEQ);
    chk("alert masked", 8'h00, {7'h00, alert_output_r});
    u_tasm_host.rd(8'h44, d);
    chk("alert status", 8'h44, d);
    drive(56'h0, 6'h00, 6'h00);
    u_tasm_host.wr(8'h42, 8'h00);
    step(SEQ);
    u_tasm_host.rd(8'h44, d);
    chk("alert quiet", 8'h00, {7'h00, alert_output_r});
  endtask : t_alert
  task automatic t_ot();
    drive(56'h70, 6'h00, 6'h00);
    step(SEQ);
    chk("ot out", 8'h01, {7'h00, overtemp_output_r});
    wait_chan(3'h1);
    u_tasm_host.rd(8'h45, d);
    chk("ot status", 8'h01, d);
    u_tasm_host.rd(8'h45, d);
    chk("ot cleared", 8'h00, d);
    chk("ot held", 8'h01, {7'h00, overtemp_output_r});
    u_tasm_host.wr(8'h43, 8'h01);
    step(3);
    chk("ot masked", 8'h00, {7'h00, overtemp_output_r});
    u_tasm_host.wr(8'h43, 8'h00);
    drive(56'h6B, 6'h00, 6'h00);
    step(SEQ);
    chk("ot hyst", 8'h01, {7'h00, overtemp_output_r});
    drive(56'h60, 6'h00, 6'h00);
    step(SEQ);
    chk("ot release", 8'h00, {7'h00, overtemp_output_r});
    u_tasm_host.rd(8'h44, d);
    u_tasm_host.rd(8'h45, d);
  endtask : t_ot
  task automatic t_fault();
    drive(56'h0, 6'h02, 6'h10);
    u_tasm_host.mask_unused(7'h12);
    step(SEQ);
    u_tasm_host.rd(8'h46, d);
    chk("fault status", 8'h24, d);
    n = 0;
    for (int i = 0; i < SEQ; i++) begin
      step(1);
      if (meas_chan_r === 3'h1 || meas_chan_r === 3'h4) n++;
    end
    chk("skipped", 8'h00, 8'(n));
    drive(56'h0, 6'h00, 6'h00);
  endtask : t_fault
  task automatic t_rcancel();
    slot_len(n);
    chk("slot plain", 8'(SL), 8'(n));
    u_tasm_host.wr(8'h41, 8'h08);
    rc_seen = 1'b0;
    slot_len(n);
    chk("slot long", 8'(SL + RC), 8'(n));
    chk("cancel on", 8'h01, {7'h00, rc_seen});
    u_tasm_host.wr(8'h41, 8'h00);
  endtask : t_rcancel
  initial begin
    reset = 1'b1;
    rc_seen = 1'b0;
    temp_in = 56'h0;
    diode_open = 6'h00;
    anode_at_supply = 6'h00;
    step(20);
    reset = 1'b0;
    t_reset();
    t_alert();
    t_ot();
    t_fault();
    t_rcancel();
    stop_test();
  end
endmodule : tasm_top_tb
